// file: core/wds_map.svh
`ifndef WDS_MAP_SVH
`define WDS_MAP_SVH

// Register offsets (byte addresses)
`define WDS_OFF_SAFETY_CFG   8'h00
`define WDS_OFF_CHECK_CTRL   8'h04
`define WDS_OFF_CLOSE_CFG    8'h08
`define WDS_OFF_OPEN_CFG     8'h0c
`define WDS_OFF_STATUS       8'h10
`define WDS_OFF_QA_ANSWER    8'h14

// Field positions
`define WDS_BIT_RST_EN       3
`define WDS_BIT_QA_MODE      5
`define WDS_BIT_DRV_REQ      0
`define WDS_BIT_GO_ACTIVE    1
`define WDS_BIT_TIMEOUT      1
`define WDS_BIT_OUT_RANGE    0
`define WDS_BIT_ANS_OK       0
`define WDS_FLD_CNT_LO       4
`define WDS_FLD_STATE_LO     8

// Reset and load values
`define WDS_CLOSE_DEFAULT    7'h10
`define WDS_OPEN_DEFAULT     5'h0a
`define WDS_FAIL_LOAD        3'h5
`define WDS_FAIL_MAX         3'h7
`define WDS_FAIL_OUT_RANGE   3'h5

// Timing
`define WDS_CLK_NS           4
`define WDS_STEP_NS          550000
`define WDS_PULSE_NS         32000
`define WDS_RESET_HOLD_CYC   16

`endif

// file: core/wds_pkg.sv
package wds_pkg;

  typedef enum logic [2:0] {
    WDS_ST_RESET  = 3'b001,
    WDS_ST_DIAG   = 3'b010,
    WDS_ST_ACTIVE = 3'b100
  } wds_state_t;

  typedef struct packed {
    logic good;
    logic bad;
    logic timeout;
  } wds_evt_t;

  typedef struct packed {
    logic [6:0] close_set;
    logic [4:0] open_set;
    logic       qa_mode;
    logic       rst_en;
    logic       drv_req;
  } wds_cfg_t;

endpackage

// file: core/wds_trigger_filter.sv
`timescale 1ns/1ps
`default_nettype none
`include "wds_map.svh"

module wds_trigger_filter
  import wds_pkg::*;
#(
  parameter int unsigned PULSE_CYC = 8000
) (
  input  wire logic mclk,
  input  wire logic rst,
  input  wire logic trigger_input,
  output logic      trig_pulse
);

  logic        sync1_q;
  logic        sync2_q;
  logic        level_q;
  logic [13:0] high_cnt_q;

  // Pin is asynchronous to mclk
  always_ff @(posedge mclk) begin
    if (rst) begin
      sync1_q <= 1'b0;
      sync2_q <= 1'b0;
      level_q <= 1'b0;
    end else begin
      sync1_q <= trigger_input;
      sync2_q <= sync1_q;
      level_q <= sync2_q;
    end
  end

  // Saturates one past the limit so the long-high case still qualifies
  always_ff @(posedge mclk) begin
    if (rst || !sync2_q) begin
      high_cnt_q <= 14'h0000;
    end else if (high_cnt_q <= 14'(PULSE_CYC)) begin
      high_cnt_q <= high_cnt_q + 14'h0001;
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      trig_pulse <= 1'b0;
    end else begin
      trig_pulse <= level_q && !sync2_q
                    && (high_cnt_q > 14'(PULSE_CYC));
    end
  end

endmodule // wds_trigger_filter

`default_nettype wire

// file: core/wds_supervisor.sv
// Decided for this implementation: the APB interface to the registers and the register offsets.
`timescale 1ns/1ps
`default_nettype none
`include "wds_map.svh"

module wds_supervisor
  import wds_pkg::*;
#(
  parameter int unsigned STEP_CYC  = `WDS_STEP_NS / `WDS_CLK_NS,
  parameter int unsigned PULSE_CYC = (`WDS_PULSE_NS + `WDS_CLK_NS - 1)
                                     / `WDS_CLK_NS
) (
  input  wire logic        mclk,
  input  wire logic        rst,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        trigger_input,
  input  wire logic        other_error,
  output logic             drive_enable_out,
  output logic             mcu_reset_n,
  output logic             out_of_range
);

  localparam int unsigned RST_HOLD_CYC = `WDS_RESET_HOLD_CYC;

  function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
    hit = (a == off);
  endfunction

  wds_state_t  state_q;
  wds_cfg_t    cfg_q;
  wds_evt_t    evt_d;
  wds_evt_t    evt_q;
  logic [2:0]  supervisor_fail_count_q;
  logic        timeout_flag_q;
  logic        rst_en_prev_q;
  logic [4:0]  hold_q;
  logic [17:0] pre_q;
  logic [6:0]  win_cnt_q;
  logic        open_q;
  logic        restart_q;
  logic        err_s1_q;
  logic        err_s2_q;
  logic        trig_pulse;
  logic        wr_take;
  logic        tick;
  logic        running;
  logic        win_wr;
  logic        go_active;
  logic        qa_wr;
  logic        fail_evt;
  logic        wd_fail;
  logic        mapped;
  logic [31:0] rd_data;

  wds_trigger_filter #(
    .PULSE_CYC (PULSE_CYC)
  ) wds_trigger_filter_inst (
    .mclk          (mclk),
    .rst           (rst),
    .trigger_input (trigger_input),
    .trig_pulse    (trig_pulse)
  );

  // APB: one wait state, write lands at the completing edge
  assign wr_take   = psel && penable && pready && pwrite;
  assign win_wr    = wr_take && (hit(paddr, `WDS_OFF_CLOSE_CFG)
                              || hit(paddr, `WDS_OFF_OPEN_CFG));
  assign go_active = wr_take && hit(paddr, `WDS_OFF_CHECK_CTRL)
                     && pwdata[`WDS_BIT_GO_ACTIVE];
  assign qa_wr     = wr_take && hit(paddr, `WDS_OFF_QA_ANSWER);
  assign mapped    = hit(paddr, `WDS_OFF_SAFETY_CFG)
                     || hit(paddr, `WDS_OFF_CHECK_CTRL)
                     || hit(paddr, `WDS_OFF_CLOSE_CFG)
                     || hit(paddr, `WDS_OFF_OPEN_CFG)
                     || hit(paddr, `WDS_OFF_STATUS)
                     || hit(paddr, `WDS_OFF_QA_ANSWER);
  assign running   = (state_q != WDS_ST_RESET);

  always_comb begin
    rd_data = 32'h0000_0000;
    if (hit(paddr, `WDS_OFF_SAFETY_CFG)) begin
      rd_data[`WDS_BIT_RST_EN]  = cfg_q.rst_en;
      rd_data[`WDS_BIT_QA_MODE] = cfg_q.qa_mode;
    end else if (hit(paddr, `WDS_OFF_CHECK_CTRL)) begin
      rd_data[`WDS_BIT_DRV_REQ] = cfg_q.drv_req;
    end else if (hit(paddr, `WDS_OFF_CLOSE_CFG)) begin
      rd_data[6:0] = cfg_q.close_set;
    end else if (hit(paddr, `WDS_OFF_OPEN_CFG)) begin
      rd_data[4:0] = cfg_q.open_set;
    end else if (hit(paddr, `WDS_OFF_STATUS)) begin
      rd_data[`WDS_BIT_OUT_RANGE] = out_of_range;
      rd_data[`WDS_BIT_TIMEOUT]   = timeout_flag_q;
      rd_data[`WDS_FLD_CNT_LO +: 3]   = supervisor_fail_count_q;
      rd_data[`WDS_FLD_STATE_LO +: 3] = state_q;
    end
  end

  // Ready is a one-cycle pulse; prdata holds until the next answer, and a write answer loads zero
  // Arming only on !pready keeps a held request from answering in two consecutive cycles
  always_ff @(posedge mclk) begin
    if (rst) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
    end else if (psel && penable && !pready) begin
      pready  <= 1'b1;
      pslverr <= !mapped;
      prdata  <= pwrite ? 32'h0000_0000 : rd_data;
    end else begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end
  end

  // Configuration; reset state restores defaults for the next diagnostic
  always_ff @(posedge mclk) begin
    if (rst || state_q == WDS_ST_RESET) begin
      cfg_q.close_set <= `WDS_CLOSE_DEFAULT;
      cfg_q.open_set  <= `WDS_OPEN_DEFAULT;
      cfg_q.qa_mode   <= 1'b0;
      cfg_q.rst_en    <= 1'b0;
      cfg_q.drv_req   <= 1'b0;
    end else if (wr_take) begin
      if (hit(paddr, `WDS_OFF_SAFETY_CFG)) begin
        cfg_q.rst_en <= pwdata[`WDS_BIT_RST_EN];
        if (state_q == WDS_ST_DIAG) begin
          cfg_q.qa_mode <= pwdata[`WDS_BIT_QA_MODE];
        end
      end
      if (hit(paddr, `WDS_OFF_CHECK_CTRL)) begin
        cfg_q.drv_req <= pwdata[`WDS_BIT_DRV_REQ];
      end
      // Locked outside diagnostic, yet the write still restarts
      if (state_q == WDS_ST_DIAG) begin
        if (hit(paddr, `WDS_OFF_CLOSE_CFG)) begin
          cfg_q.close_set <= pwdata[6:0];
        end
        if (hit(paddr, `WDS_OFF_OPEN_CFG)) begin
          cfg_q.open_set <= pwdata[4:0];
        end
      end
    end
  end

  // Device state machine
  // A window write is not a failure event, so it never resets the controller
  // Rising reset enable alone fires when the count already sits at seven
  assign fail_evt = evt_q.bad || evt_q.timeout;
  assign wd_fail  = cfg_q.rst_en && supervisor_fail_count_q == `WDS_FAIL_MAX
                    && (fail_evt || !rst_en_prev_q);

  always_ff @(posedge mclk) begin
    if (rst) begin
      rst_en_prev_q <= 1'b0;
    end else begin
      rst_en_prev_q <= cfg_q.rst_en;
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      state_q <= WDS_ST_RESET;
      hold_q  <= 5'h00;
    end else begin
      unique case (state_q)
        WDS_ST_RESET: begin
          hold_q <= hold_q + 5'h01;
          if (hold_q == 5'(RST_HOLD_CYC - 1)) begin
            state_q <= WDS_ST_DIAG;
          end
        end
        WDS_ST_DIAG: begin
          hold_q <= 5'h00;
          if (wd_fail) begin
            state_q <= WDS_ST_RESET;
          end else if (go_active) begin
            state_q <= WDS_ST_ACTIVE;
          end
        end
        WDS_ST_ACTIVE: begin
          hold_q <= 5'h00;
          if (wd_fail) begin
            state_q <= WDS_ST_RESET;
          end
        end
        default: begin
          state_q <= WDS_ST_RESET;
          hold_q  <= 5'h00;
        end
      endcase
    end
  end

  // Time step prescaler, realigned with every sequence
  always_ff @(posedge mclk) begin
    if (rst || restart_q || !running) begin
      pre_q <= 18'h00000;
    end else if (tick) begin
      pre_q <= 18'h00000;
    end else begin
      pre_q <= pre_q + 18'h00001;
    end
  end
  assign tick = (pre_q == 18'(STEP_CYC - 1));

  // Event classification; ignored while a restart is pending
  // Trades a two-cycle blind spot for one event per sequence
  always_comb begin
    evt_d = '0;
    if (running && !restart_q && !(|evt_q)) begin
      if (cfg_q.qa_mode ? qa_wr : trig_pulse) begin
        if (open_q && (!cfg_q.qa_mode || pwdata[`WDS_BIT_ANS_OK])) begin
          evt_d.good = 1'b1;
        end else begin
          evt_d.bad = 1'b1;
        end
      end else if (open_q && tick
                   && win_cnt_q == {2'b00, cfg_q.open_set}) begin
        evt_d.timeout = 1'b1;
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      evt_q     <= '0;
      restart_q <= 1'b0;
    end else begin
      evt_q     <= evt_d;
      restart_q <= (|evt_q) || win_wr;
    end
  end

  // Close window then open window
  always_ff @(posedge mclk) begin
    if (rst || restart_q || !running) begin
      win_cnt_q <= 7'h00;
      open_q    <= (cfg_q.close_set == 7'h00);
    end else if (tick) begin
      if (!open_q && win_cnt_q + 7'h01 >= cfg_q.close_set) begin
        open_q    <= 1'b1;
        win_cnt_q <= 7'h00;
      end else begin
        win_cnt_q <= win_cnt_q + 7'h01;
      end
    end
  end

  // Fail counter, independent of the reset enable bit
  always_ff @(posedge mclk) begin
    if (rst || state_q == WDS_ST_RESET) begin
      supervisor_fail_count_q <= `WDS_FAIL_LOAD;
    end else if (go_active && state_q == WDS_ST_DIAG) begin
      supervisor_fail_count_q <= `WDS_FAIL_LOAD;
    end else if (evt_q.good) begin
      if (supervisor_fail_count_q != 3'h0) begin
        supervisor_fail_count_q <= supervisor_fail_count_q - 3'h1;
      end
    end else if (fail_evt || win_wr) begin
      if (supervisor_fail_count_q != `WDS_FAIL_MAX) begin
        supervisor_fail_count_q <= supervisor_fail_count_q + 3'h1;
      end
    end
  end

  // Set wins over a same-cycle clear
  always_ff @(posedge mclk) begin
    if (rst) begin
      timeout_flag_q <= 1'b0;
    end else if (evt_q.timeout) begin
      timeout_flag_q <= 1'b1;
    end else if (wr_take && hit(paddr, `WDS_OFF_STATUS)
                 && pwdata[`WDS_BIT_TIMEOUT]) begin
      timeout_flag_q <= 1'b0;
    end
  end

  // Other error pin is asynchronous
  // Resets high so drive stays off until the pin is seen low
  always_ff @(posedge mclk) begin
    if (rst) begin
      err_s1_q <= 1'b1;
      err_s2_q <= 1'b1;
    end else begin
      err_s1_q <= other_error;
      err_s2_q <= err_s1_q;
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      out_of_range     <= 1'b1;
      drive_enable_out <= 1'b0;
      mcu_reset_n      <= 1'b0;
    end else begin
      out_of_range     <= supervisor_fail_count_q >= `WDS_FAIL_OUT_RANGE;
      drive_enable_out <= running && cfg_q.drv_req && !err_s2_q
                          && supervisor_fail_count_q < `WDS_FAIL_OUT_RANGE
                          && !wd_fail;
      mcu_reset_n      <= running && !wd_fail;
    end
  end

endmodule // wds_supervisor

`default_nettype wire

// file: bench/wds_supervisor_sva.sv
`timescale 1ns/1ps
`default_nettype none

module wds_supervisor_chk (
  input wire logic mclk,
  input wire logic rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic other_error,
  input wire logic drive_enable_out,
  input wire logic mcu_reset_n,
  input wire logic out_of_range
);
  default clocking @(posedge mclk); endclocking
  default disable iff (rst);

  // One cycle of slack: count and outputs may settle on adjacent edges
  oor_drive_a: assert property (
    out_of_range && $past(out_of_range) |-> !drive_enable_out)
    else $error("drive enable high while out of range");
  rst_drive_a: assert property (
    !mcu_reset_n && $past(mcu_reset_n == 1'b0) |-> !drive_enable_out)
    else $error("drive enable high in reset state");
  err_drive_a: assert property (
    other_error [*5] |-> !drive_enable_out)
    else $error("drive enable high despite other error");
  drive_cause_a: assert property (
    $rose(drive_enable_out) |-> !out_of_range && mcu_reset_n)
    else $error("drive enable rose without in-range count");
  reset_hold_a: assert property (
    $fell(mcu_reset_n) |=> !mcu_reset_n [*8])
    else $error("reset output released too early");
  reset_load_a: assert property (
    !mcu_reset_n && $past(mcu_reset_n == 1'b0) |-> out_of_range)
    else $error("count not reloaded in reset state");
  diag_load_a: assert property (
    $rose(mcu_reset_n) |-> out_of_range && !drive_enable_out)
    else $error("count not loaded on entering diagnostic");
  apb_wait_a: assert property (
    psel && !penable |-> ##2 pready)
    else $error("register access answer late");
  apb_pulse_a: assert property (
    pready |=> !pready && !pslverr)
    else $error("ready or error held over one cycle");

  cover property ($fell(mcu_reset_n));
  cover property ($rose(drive_enable_out));
  cover property (pready && pslverr);
endmodule // wds_supervisor_chk

`default_nettype wire

// file: bench/wds_mcu_model.sv
`timescale 1ns/1ps
`default_nettype none

module wds_mcu_model #(
  parameter int unsigned PULSE_CYC = 10
) (
  input  wire logic mclk,
  output logic      trigger_input
);
  // Error monitor never used here: model only runs trigger mode
  initial trigger_input = 1'b0;

  // Push-pull pin, so low between pulses is a driven level
  task automatic pulse(input int unsigned dly);
    repeat (dly) @(posedge mclk);
    trigger_input <= 1'b1;
    repeat (PULSE_CYC + 2) @(posedge mclk);
    trigger_input <= 1'b0;
  endtask
endmodule // wds_mcu_model

`default_nettype wire

// file: bench/test_wds_supervisor.sv
`timescale 1ns/1ps
`default_nettype none
`include "wds_map.svh"

module test_wds_supervisor
  import wds_pkg::*;
;
  localparam logic [31:0] MS = 32'hfffffffd;
  logic        mclk, rst, psel, penable, pwrite, pready, pslverr;
  logic        other_error, drive_enable_out, mcu_reset_n;
  logic        out_of_range, trigger_input, er_v;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rd_v;
  int          errors, num_checks, cyc;

  always #2 mclk = ~mclk;

  wds_supervisor #(.STEP_CYC(20), .PULSE_CYC(10)) wds_supervisor_inst (
    .mclk             (mclk),
    .rst              (rst),
    .psel             (psel),
    .penable          (penable),
    .pwrite           (pwrite),
    .paddr            (paddr),
    .pwdata           (pwdata),
    .prdata           (prdata),
    .pready           (pready),
    .pslverr          (pslverr),
    .trigger_input    (trigger_input),
    .other_error      (other_error),
    .drive_enable_out (drive_enable_out),
    .mcu_reset_n      (mcu_reset_n),
    .out_of_range     (out_of_range));

  wds_mcu_model #(.PULSE_CYC(10)) wds_mcu_model_inst (
    .mclk          (mclk),
    .trigger_input (trigger_input));

  task automatic chk(input string nm, input logic [31:0] seen, exp);
    num_checks++;
    if (seen !== exp) begin
      errors++;
      $display("Error %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    int n;
    n = 0;
    @(posedge mclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    @(posedge mclk);
    while (pready !== 1'b1 && n < 20) begin
      @(posedge mclk);
      n++;
    end
    if (n == 20) chk("pready", 32'(pready), 32'h1);
    rd_v = prdata;
    er_v = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] exp,
                    input logic [31:0] m = 32'hffffffff);
    apb(1'b0, a, 32'h0);
    chk("prdata", rd_v & m, exp);
  endtask

  task automatic wait_rn(input logic v);
    int n;
    n = 0;
    while (mcu_reset_n !== v && n < 100) begin
      @(posedge mclk);
      n++;
    end
    chk("mcu_reset_n", 32'(mcu_reset_n), 32'(v));
  endtask

  function automatic logic [31:0] st(logic [2:0] s, logic [2:0] c,
                                     logic t);
    return {21'h0, s, 1'b0, c, 2'b0, t, c >= 3'h5};
  endfunction

  task automatic wrap_up;
    $display("checks %0d errors %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  always @(posedge mclk) begin
    cyc++;
    if (cyc == 20000) begin
      errors++;
      wrap_up();
    end
  end

  initial begin
    {mclk, psel, penable, pwrite, other_error} = '0;
    rst = 1'b1;
    paddr = 8'h00;
    pwdata = 32'h0;
    repeat (2) @(posedge mclk);
    rst <= 1'b0;
    wait_rn(1'b1);
    rd(`WDS_OFF_STATUS, st(WDS_ST_DIAG, 3'h5, 1'b0), MS);
    chk("out_of_range", 32'(out_of_range), 32'h1);
    rd(`WDS_OFF_CLOSE_CFG, 32'h10);
    rd(`WDS_OFF_OPEN_CFG, 32'h0a);
    rd(`WDS_OFF_SAFETY_CFG, 32'h0);
    rd(8'h40, 32'h0);
    chk("pslverr", 32'(er_v), 32'h1);
    wr(`WDS_OFF_CHECK_CTRL, 32'h1);
    wr(`WDS_OFF_CLOSE_CFG, 32'h2);
    wr(`WDS_OFF_OPEN_CFG, 32'h3);
    rd(`WDS_OFF_CLOSE_CFG, 32'h2);
    rd(`WDS_OFF_STATUS, st(WDS_ST_DIAG, 3'h7, 1'b0), MS);
    // Early trigger lands in the two-step close window
    wds_mcu_model_inst.pulse(0);
    repeat (8) @(posedge mclk);
    rd(`WDS_OFF_STATUS, st(WDS_ST_DIAG, 3'h7, 1'b0), MS);
    for (int i = 0; i < 8; i++) begin
      wds_mcu_model_inst.pulse(50);
      repeat (8) @(posedge mclk);
      rd(`WDS_OFF_STATUS, st(WDS_ST_DIAG, (i < 6) ? 3'(6 - i) : 3'h0,
         1'b0), MS);
      if (i == 2) begin
        chk("drive", 32'(drive_enable_out), 32'h1);
        chk("out_of_range", 32'(out_of_range), 32'h0);
        other_error <= 1'b1;
        repeat (6) @(posedge mclk);
        chk("drive", 32'(drive_enable_out), 32'h0);
        other_error <= 1'b0;
      end
    end
    repeat (150) @(posedge mclk);
    rd(`WDS_OFF_STATUS, st(WDS_ST_DIAG, 3'h1, 1'b1));
    wr(`WDS_OFF_STATUS, 32'h2);
    rd(`WDS_OFF_STATUS, st(WDS_ST_DIAG, 3'h1, 1'b0));
    wr(`WDS_OFF_CHECK_CTRL, 32'h3);
    rd(`WDS_OFF_STATUS, st(WDS_ST_ACTIVE, 3'h5, 1'b0), MS);
    wr(`WDS_OFF_CLOSE_CFG, 32'h5);
    rd(`WDS_OFF_CLOSE_CFG, 32'h2);
    wr(`WDS_OFF_SAFETY_CFG, 32'h20);
    rd(`WDS_OFF_SAFETY_CFG, 32'h0);
    wr(`WDS_OFF_OPEN_CFG, 32'h3);
    rd(`WDS_OFF_STATUS, st(WDS_ST_ACTIVE, 3'h7, 1'b0), MS);
    wr(`WDS_OFF_SAFETY_CFG, 32'h8);
    wait_rn(1'b0);
    wait_rn(1'b1);
    rd(`WDS_OFF_STATUS, st(WDS_ST_DIAG, 3'h5, 1'b0), MS);
    rd(`WDS_OFF_CLOSE_CFG, 32'h10);
    rd(`WDS_OFF_SAFETY_CFG, 32'h0);
    wr(`WDS_OFF_SAFETY_CFG, 32'h8);
    wr(`WDS_OFF_CLOSE_CFG, 32'h2);
    wr(`WDS_OFF_CLOSE_CFG, 32'h2);
    chk("mcu_reset_n", 32'(mcu_reset_n), 32'h1);
    wds_mcu_model_inst.pulse(0);
    wait_rn(1'b0);
    wait_rn(1'b1);
    wr(`WDS_OFF_SAFETY_CFG, 32'h20);
    rd(`WDS_OFF_SAFETY_CFG, 32'h20);
    // Pin triggers must be ignored once answers come over the bus
    wds_mcu_model_inst.pulse(0);
    repeat (8) @(posedge mclk);
    rd(`WDS_OFF_STATUS, st(WDS_ST_DIAG, 3'h5, 1'b0), MS);
    // Correct answer inside the close window still counts as bad
    wr(`WDS_OFF_QA_ANSWER, 32'h1);
    rd(`WDS_OFF_STATUS, st(WDS_ST_DIAG, 3'h6, 1'b0), MS);
    wr(`WDS_OFF_CLOSE_CFG, 32'h2);
    repeat (50) @(posedge mclk);
    wr(`WDS_OFF_QA_ANSWER, 32'h1);
    rd(`WDS_OFF_STATUS, st(WDS_ST_DIAG, 3'h6, 1'b0), MS);
    wrap_up();
  end
endmodule // test_wds_supervisor

bind wds_supervisor wds_supervisor_chk wds_supervisor_chk_inst (
  .mclk, .rst, .psel, .penable, .pready, .pslverr, .other_error,
  .drive_enable_out, .mcu_reset_n, .out_of_range);

`default_nettype wire
